// ==== design/sip_pkg.sv ====
// Purpose: Constants for the status indicator pattern generator
// Assumes: 125 MHz system clock, 32-bit APB register access
// Notes: Register index kept as printed; byte address is four times it
package sip_pkg;
  localparam logic [15:0] IND2_CTRL_IDX = 16'h404d;
  localparam logic [17:0] IND2_CTRL_ADDR = {IND2_CTRL_IDX, 2'b00};
  localparam int SRC_LSB = 14;
  localparam int PAT_LSB = 8;
  localparam int CNT_LSB = 4;
  localparam int ONT_LSB = 2;
  localparam int RAT_LSB = 0;
  localparam logic [1:0] SRC_RST = 2'h3;
  localparam logic [1:0] PAT_RST = 2'h0;
  localparam logic [1:0] CNT_RST = 2'h2;
  localparam logic [1:0] ONT_RST = 2'h1;
  localparam logic [1:0] RAT_RST = 2'h2;
  localparam logic [15:0] WR_MASK = 16'hc33f;
  // Timebase: one tick per 62.5 ms
  localparam int CLK_HZ = 125000000;
  localparam int TICK_US = 62500;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  // Off gap after a burst, in ticks (2 s)
  localparam int BURST_GAP_TICKS = 32;
  typedef enum logic [1:0] {SRC_OFF = 2'h0, SRC_PWR = 2'h1, SRC_CHG = 2'h2,
    SRC_MAN = 2'h3} sip_src_t;
  typedef enum logic [1:0] {PAT_OFF = 2'h0, PAT_ON = 2'h1, PAT_PULSE = 2'h2,
    PAT_BURST = 2'h3} sip_pat_t;
endpackage : sip_pkg

// ==== design/sip_tick.sv ====
// Purpose: Divider giving a one-cycle tick every 62.5 ms
// Assumes: Active-low reset, already released through the top's synchroniser
// Notes: Restart clears the phase so a new pattern starts cleanly
`timescale 1ns/1ps
module sip_tick
  import sip_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic restart_i,
  // Timebase
  output logic tick_o
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (restart_i || cnt_ff == 32'(TICK_CYCLES - 1))
    begin
      cnt_ff <= 32'h0;
      tick_o <= !restart_i;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : sip_tick

// ==== design/sip_top.sv ====
// Purpose: Pattern generator driving the second status indicator
// Assumes: APB slave, one clock, indications arrive synchronous
// Notes: Pattern timing runs from a 62.5 ms tick
// What this block does
// - Bits 15:14 pick off, power state, charger or manual; reset manual.
// - Programming-memory auto-program error also lights the indicator.
// - Manual pattern bits 9:8 matter only when source is manual.
// - Pattern codes off, on, continuous pulsing, counted burst; reset off.
// - Burst length bits 5:4 give 1, 2, 4, 7 pulses; reset 4.
// - On time bits 3:2 give 1 s, 250, 125, 62.5 ms; reset 250 ms.
// - Ratio bits 1:0 give 1:1, 1:2, 1:3, 1:7; reset 1:3.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module sip_top
  import sip_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Indication sources
  input wire logic PWR_STATE_IND_I,
  input wire logic CHARGER_IND_I,
  input wire logic OTP_PROG_ERR_I,
  // Indicator drive
  output logic INDICATOR_O
);
  logic rst_s1_ff, rst_n;
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  function automatic logic [3:0] on_ticks(input logic [1:0] c);
    case (c)
      2'h0: on_ticks = 4'd15;
      2'h1: on_ticks = 4'd3;
      2'h2: on_ticks = 4'd1;
      default: on_ticks = 4'd0;
    endcase
  endfunction : on_ticks

  logic [15:0] ctrl_ff;
  logic acc, hit, wr_ok;
  assign acc = PSEL_I && PENABLE_I;
  assign hit = PADDR_I[31:18] == 14'h0 && PADDR_I[17:0] == IND2_CTRL_ADDR;
  assign wr_ok = acc && PWRITE_I && hit;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc && !hit;

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= {SRC_RST, 4'h0, PAT_RST, 2'h0, CNT_RST, ONT_RST, RAT_RST};
    else if (wr_ok)
      ctrl_ff <= PWDATA_I[15:0] & WR_MASK;
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      PRDATA_O <= 32'h0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
      PRDATA_O <= (PADDR_I[17:0] == IND2_CTRL_ADDR && PADDR_I[31:18] == 14'h0) ?
        {16'h0, ctrl_ff} : 32'h0;
  end

  sip_src_t src;
  sip_pat_t pat;
  logic [1:0] cnt_c, ont_c, rat_c;
  assign src = sip_src_t'(ctrl_ff[SRC_LSB +: 2]);
  assign pat = sip_pat_t'(ctrl_ff[PAT_LSB +: 2]);
  assign cnt_c = ctrl_ff[CNT_LSB +: 2];
  assign ont_c = ctrl_ff[ONT_LSB +: 2];
  assign rat_c = ctrl_ff[RAT_LSB +: 2];

  logic restart;
  assign restart = wr_ok;
  logic tick;
  sip_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_n),
    .restart_i(restart),
    .tick_o(tick)
  );

  logic [2:0] pulses;
  logic [3:0] on_len;
  logic [6:0] off_len;
  assign pulses = (cnt_c == 2'h0) ? 3'd1 : (cnt_c == 2'h1) ? 3'd2 :
    (cnt_c == 2'h2) ? 3'd4 : 3'd7;
  assign on_len = on_ticks(ont_c);
  always_comb
  begin
    case (rat_c)
      2'h0: off_len = 7'({3'h0, on_len} + 7'd0);
      2'h1: off_len = 7'({3'h0, on_len} * 7'd2 + 7'd1);
      2'h2: off_len = 7'({3'h0, on_len} * 7'd3 + 7'd2);
      default: off_len = 7'({3'h0, on_len} * 7'd7 + 7'd6);
    endcase
  end

  typedef enum logic [2:0] {PH_ON = 3'b001, PH_OFF = 3'b010, PH_GAP = 3'b100} sip_ph_t;
  sip_ph_t ph_ff;
  logic [6:0] tcnt_ff;
  logic [2:0] pcnt_ff;
  logic pulsing;
  assign pulsing = pat == PAT_PULSE || pat == PAT_BURST;

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_ff <= PH_ON;
      tcnt_ff <= 7'h0;
      pcnt_ff <= 3'h0;
    end
    else if (restart || !pulsing)
    begin
      ph_ff <= PH_ON;
      tcnt_ff <= 7'h0;
      pcnt_ff <= 3'h0;
    end
    else if (tick)
    begin
      case (ph_ff)
        PH_ON:
          if (tcnt_ff >= {3'h0, on_len})
          begin
            ph_ff <= PH_OFF;
            tcnt_ff <= 7'h0;
          end
          else
            tcnt_ff <= tcnt_ff + 7'h1;
        PH_OFF:
          if (tcnt_ff >= off_len)
          begin
            tcnt_ff <= 7'h0;
            if (pat == PAT_BURST && pcnt_ff + 3'h1 >= pulses)
            begin
              ph_ff <= PH_GAP;
              pcnt_ff <= 3'h0;
            end
            else
            begin
              ph_ff <= PH_ON;
              pcnt_ff <= (pat == PAT_BURST) ? pcnt_ff + 3'h1 : 3'h0;
            end
          end
          else
            tcnt_ff <= tcnt_ff + 7'h1;
        PH_GAP:
          if (tcnt_ff >= 7'(BURST_GAP_TICKS - 1))
          begin
            ph_ff <= PH_ON;
            tcnt_ff <= 7'h0;
          end
          else
            tcnt_ff <= tcnt_ff + 7'h1;
        default:
          ph_ff <= PH_ON;
      endcase
    end
  end

  logic man_out, nxt_out;
  always_comb
  begin
    case (pat)
      PAT_ON: man_out = 1'b1;
      PAT_PULSE, PAT_BURST: man_out = ph_ff == PH_ON;
      default: man_out = 1'b0;
    endcase
    case (src)
      SRC_PWR: nxt_out = PWR_STATE_IND_I;
      SRC_CHG: nxt_out = CHARGER_IND_I;
      SRC_MAN: nxt_out = man_out;
      default: nxt_out = 1'b0;
    endcase
    nxt_out = nxt_out | OTP_PROG_ERR_I;
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      INDICATOR_O <= 1'b0;
    else
      INDICATOR_O <= nxt_out;
  end

  // Assertions
  a_err_lights: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    OTP_PROG_ERR_I |=> INDICATOR_O) else $error("error not shown");
  a_src_off_dark: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (src == SRC_OFF && !OTP_PROG_ERR_I) |=> !INDICATOR_O) else $error("off source lit");
  a_pat_ignored: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (src == SRC_CHG && !OTP_PROG_ERR_I) |=> INDICATOR_O == $past(CHARGER_IND_I))
    else $error("charger not followed");
  a_man_const: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (src == SRC_MAN && pat == PAT_ON) |=> INDICATOR_O) else $error("constant not on");
  a_burst_count: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    pcnt_ff < pulses) else $error("burst count overrun");
  a_on_bound: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    ph_ff == PH_ON |-> tcnt_ff <= {3'h0, on_len}) else $error("on time overrun");
  a_off_bound: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    ph_ff == PH_OFF |-> tcnt_ff <= off_len) else $error("off time overrun");
  a_restart_on: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    restart |=> ph_ff == PH_ON && tcnt_ff == 7'h0) else $error("no restart");
  c_burst_gap: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) ph_ff == PH_GAP);
  c_pulse_off: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    pat == PAT_PULSE && ph_ff == PH_OFF);
  c_write: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) wr_ok);
endmodule : sip_top

// ==== tb/sip_led_model.sv ====
// Purpose: Indicator LED stand-in measuring pulse timing
// Assumes: Indicator drive active high, sampled each clock
// Notes: Lengths in cycles; it only watches, so it cannot mask a fault
`timescale 1ns/1ps
module sip_led_model
(
  // Clock and control
  input wire logic clk_i,
  input wire logic clr_i,
  // Indicator pin
  input wire logic lit_i,
  // Measurements
  output int on_len_o,
  output int off_len_o,
  output int rises_o
);
  logic prev_ff = 1'b0;
  int run_ff = 0;
  // Plain always, since the history registers start from declared values
  always @(posedge clk_i)
  begin
    prev_ff <= lit_i;
    run_ff <= (lit_i != prev_ff) ? 1 : run_ff + 1;
    if (lit_i && !prev_ff)
      off_len_o <= run_ff;
    if (!lit_i && prev_ff)
      on_len_o <= run_ff;
    rises_o <= clr_i ? 0 : rises_o + int'(lit_i && !prev_ff);
  end
endmodule : sip_led_model

// ==== tb/test_sip_top.sv ====
// Purpose: Self-checking bench for the indicator pattern generator
// Assumes: Tick shortened to 4 cycles; burst gap of 32 ticks
// Notes: Timing is measured by the LED model, not by the bench
`timescale 1ns/1ps
module test_sip_top;
  import sip_pkg::*;
  localparam int TC = 4;
  localparam logic [31:0] CA = 32'(IND2_CTRL_ADDR);
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, er = 0, pready, pslverr, lit;
  logic s_pwr = 0, s_chg = 0, s_err = 0, clr = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd = 0, prdata, sd = 32'h3edacdbe;
  int on_len, off_len, rises, mismatches = 0, checked = 0;
  always #4 clk = ~clk;
  sip_top #(.TICK_CYCLES(TC)) DUT (.SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PWR_STATE_IND_I(s_pwr), .CHARGER_IND_I(s_chg),
    .OTP_PROG_ERR_I(s_err), .INDICATOR_O(lit));
  sip_led_model led (.clk_i(clk), .clr_i(clr), .lit_i(lit), .on_len_o(on_len),
    .off_len_o(off_len), .rises_o(rises));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic int on_cyc(input logic [1:0] c);
    return (c == 2'h0 ? 16 : c == 2'h1 ? 4 : c == 2'h2 ? 2 : 1) * TC;
  endfunction : on_cyc
  function automatic int mul(input logic [1:0] c);
    return c == 2'h3 ? 7 : int'(c) + 1;
  endfunction : mul
  function automatic int pulses(input logic [1:0] c);
    return c == 2'h3 ? 7 : 1 << c;
  endfunction : pulses
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize;
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    logic [1:0] c;
    repeat (20) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    apb(0, CA, 0);
    chk("ctrl", 32'hc026, rd);
    chk("lit", 0, {31'h0, lit});
    chk("ready", 1, {31'h0, pready});
    apb(1, CA + 4, 32'hffff);
    chk("slverr", 1, {31'h0, er});
    repeat (4)
    begin
      sd = xs(sd);
      apb(1, CA, sd);
      apb(0, CA, 0);
      chk("ctrl", sd & 32'(WR_MASK), rd);
    end
    for (int s = 0; s < 3; s++)
    begin
      apb(1, CA, 32'(s << 14) | 32'h0100);
      repeat (4)
      begin
        sd = xs(sd);
        s_pwr <= sd[0];
        s_chg <= sd[1];
        repeat (3) @(posedge clk);
        chk("src", 32'(s == 1 ? sd[0] : s == 2 ? sd[1] : 1'b0), {31'h0, lit});
      end
    end
    apb(1, CA, 32'h0100);
    s_err <= 1;
    repeat (3) @(posedge clk);
    chk("err", 1, {31'h0, lit});
    s_err <= 0;
    apb(1, CA, 32'hc100);
    repeat (3) @(posedge clk);
    chk("on", 1, {31'h0, lit});
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      apb(1, CA, {16'h0, 8'hc2, 4'h0, c, ~c});
      repeat (3 * on_cyc(c) * (1 + mul(~c)) + 8) @(posedge clk);
      chk("on_len", 32'(on_cyc(c)), 32'(on_len));
      chk("off_len", 32'(on_cyc(c) * mul(~c)), 32'(off_len));
    end
    apb(1, CA, 32'h0000c203);
    repeat (100) @(posedge clk);
    chk("off_phase", 0, {31'h0, lit});
    apb(1, CA, 32'h0000c203);
    repeat (2) @(posedge clk);
    chk("restart", 1, {31'h0, lit});
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      apb(1, CA, 32'hc000);
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      apb(1, CA, {16'h0, 8'hc3, 2'h0, c, 4'hc});
      repeat (pulses(c) * 8 + 60) @(posedge clk);
      chk("burst", 32'(pulses(c)), 32'(rises));
      repeat (pulses(c) * 8 + 128) @(posedge clk);
      chk("repeat", 32'(2 * pulses(c)), 32'(rises));
    end
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : test_sip_top
